/* dual_dac_update_format_ctrl.sv */
// Top of the dual converter control: register page decode, read mux, converter drive
`include "dac_ctrl_defs.svh"
module dual_dac_update_format_ctrl
  import dac_ctrl_pkg::*;
#(
  parameter int WORD_W = 12
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Special-function register access
  input  wire sfr_req_t          sfr,
  output logic [7:0]             sfr_rdata,
  // Timer overflow pulses
  input  wire logic              timer2_ovf,
  input  wire logic              timer3_ovf,
  input  wire logic              timer4_ovf,
  // Converter drive
  output logic [WORD_W-1:0]      chan0_code,
  output logic [WORD_W-1:0]      chan1_code,
  output logic                   chan0_enable,
  output logic                   chan1_enable,
  output logic                   chan0_pin_oe,
  output logic                   chan1_pin_oe
);
  logic              pg0;
  logic              pg1;
  logic              wr_lo0;
  logic              wr_hi0;
  logic              wr_ct0;
  logic              wr_lo1;
  logic              wr_hi1;
  logic              wr_ct1;
  logic [7:0]        lo0;
  logic [7:0]        hi0;
  logic [7:0]        ct0;
  logic [7:0]        lo1;
  logic [7:0]        hi1;
  logic [7:0]        ct1;
  logic [WORD_W-1:0] latch0;
  logic [WORD_W-1:0] latch1;
  logic [7:0]        next_sfr_rdata;
  logic              next_en0;
  logic              next_en1;

  // Same offsets on both pages; the page picks the channel
  assign pg0    = (sfr.page == `PAGE_CHAN0);
  assign pg1    = (sfr.page == `PAGE_CHAN1);
  assign wr_lo0 = sfr.write && pg0 && (sfr.addr == `ADDR_DATA_LOW);
  assign wr_hi0 = sfr.write && pg0 && (sfr.addr == `ADDR_DATA_HIGH);
  assign wr_ct0 = sfr.write && pg0 && (sfr.addr == `ADDR_CONTROL);
  assign wr_lo1 = sfr.write && pg1 && (sfr.addr == `ADDR_DATA_LOW);
  assign wr_hi1 = sfr.write && pg1 && (sfr.addr == `ADDR_DATA_HIGH);
  assign wr_ct1 = sfr.write && pg1 && (sfr.addr == `ADDR_CONTROL);

  dac_chan #(.WORD_W(WORD_W)) u_chan0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_low    (wr_lo0),
    .wr_high   (wr_hi0),
    .wr_ctl    (wr_ct0),
    .wdata     (sfr.wdata),
    .t2_ovf    (timer2_ovf),
    .t3_ovf    (timer3_ovf),
    .t4_ovf    (timer4_ovf),
    .data_low  (lo0),
    .data_high (hi0),
    .control   (ct0),
    .latch     (latch0)
  );

  // Second channel is the same module, so field positions match
  dac_chan #(.WORD_W(WORD_W)) u_chan1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_low    (wr_lo1),
    .wr_high   (wr_hi1),
    .wr_ctl    (wr_ct1),
    .wdata     (sfr.wdata),
    .t2_ovf    (timer2_ovf),
    .t3_ovf    (timer3_ovf),
    .t4_ovf    (timer4_ovf),
    .data_low  (lo1),
    .data_high (hi1),
    .control   (ct1),
    .latch     (latch1)
  );

  // Registered read data: one cycle after the read strobe; unmapped reads zero
  always_comb begin
    next_sfr_rdata = 8'h00;
    if (sfr.read) begin
      case ({pg1, pg0, sfr.addr})
        {2'b01, `ADDR_DATA_LOW}:  next_sfr_rdata = lo0;
        {2'b01, `ADDR_DATA_HIGH}: next_sfr_rdata = hi0;
        {2'b01, `ADDR_CONTROL}:   next_sfr_rdata = ct0;
        {2'b10, `ADDR_DATA_LOW}:  next_sfr_rdata = lo1;
        {2'b10, `ADDR_DATA_HIGH}: next_sfr_rdata = hi1;
        {2'b10, `ADDR_CONTROL}:   next_sfr_rdata = ct1;
        default:                  next_sfr_rdata = 8'h00;
      endcase
    end
    next_en0 = ct0[`CTL_ENABLE_BIT];
    next_en1 = ct1[`CTL_ENABLE_BIT];
  end

  // Outputs lag the control register, the latches and the read mux by one cycle so all come from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata    <= 8'h00;
      chan0_enable <= 1'b0;
      chan1_enable <= 1'b0;
      chan0_pin_oe <= 1'b0;
      chan1_pin_oe <= 1'b0;
      chan0_code   <= '0;
      chan1_code   <= '0;
    end else begin
      sfr_rdata    <= next_sfr_rdata;
      chan0_enable <= next_en0;
      chan1_enable <= next_en1;
      chan0_pin_oe <= next_en0;
      chan1_pin_oe <= next_en1;
      chan0_code   <= latch0;
      chan1_code   <= latch1;
    end
  end
endmodule

/* dac_ctrl_defs.svh */
// Offsets, field positions, reset values and update mode codes for the dual converter control
`ifndef DAC_CTRL_DEFS_SVH
`define DAC_CTRL_DEFS_SVH
`define ADDR_DATA_LOW     8'hd2
`define ADDR_DATA_HIGH    8'hd3
`define ADDR_CONTROL      8'hd4
`define PAGE_CHAN0        8'h00
`define PAGE_CHAN1        8'h01
`define CTL_ENABLE_BIT    7
`define CTL_MODE_HI       4
`define CTL_MODE_LO       3
`define CTL_FMT_HI        2
`define CTL_FMT_LO        0
`define CTL_WRITE_MASK    8'h9f
`define CTL_RESET         8'h00
`define DATA_RESET        8'h00
`define MODE_ON_WRITE     2'h0
`define MODE_TIMER3       2'h1
`define MODE_TIMER4       2'h2
`define MODE_TIMER2       2'h3
`endif

/* dac_ctrl_pkg.sv */
// Types shared by the dual converter control block
package dac_ctrl_pkg;
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef struct packed {
    logic        enable;
    logic [11:0] code;
  } conv_drive_t;
endpackage

/* dac_chan.sv */
// One converter channel: control, held data bytes, word assembly and input latch
`include "dac_ctrl_defs.svh"
module dac_chan
  import dac_ctrl_pkg::*;
#(
  parameter int WORD_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register writes already decoded for this channel
  input  wire logic              wr_low,
  input  wire logic              wr_high,
  input  wire logic              wr_ctl,
  input  wire logic [7:0]        wdata,
  // Timer overflow pulses
  input  wire logic              t2_ovf,
  input  wire logic              t3_ovf,
  input  wire logic              t4_ovf,
  // State seen by the register file and the converter
  output logic [7:0]             data_low,
  output logic [7:0]             data_high,
  output logic [7:0]             control,
  output logic [WORD_W-1:0]      latch
);
  logic [7:0]        next_data_low;
  logic [7:0]        next_data_high;
  logic [7:0]        next_control;
  logic [WORD_W-1:0] next_latch;
  logic [1:0]        mode;
  logic [2:0]        fmt;
  logic              fire;
  logic [WORD_W-1:0] word;

  assign mode = control[`CTL_MODE_HI:`CTL_MODE_LO];
  assign fmt  = control[`CTL_FMT_HI:`CTL_FMT_LO];

  always_comb begin
    next_data_low  = wr_low ? wdata : data_low;
    next_data_high = wr_high ? wdata : data_high;
    // Unused bits never store, so they read zero
    next_control   = wr_ctl ? (wdata & `CTL_WRITE_MASK) : control;
    // Word built from the bytes as they stand after this cycle's write
    if (fmt[2]) begin
      word = {next_data_high[7:0], next_data_low[7:4]};
    end else begin
      case (fmt[1:0])
        2'h0:    word = {next_data_high[3:0], next_data_low[7:0]};
        2'h1:    word = {next_data_high[4:0], next_data_low[7:1]};
        2'h2:    word = {next_data_high[5:0], next_data_low[7:2]};
        2'h3:    word = {next_data_high[6:0], next_data_low[7:3]};
        default: word = '0;
      endcase
    end
    // Pulses are one cycle wide, so each loads the latch once only
    case (mode)
      `MODE_ON_WRITE: fire = wr_high;
      `MODE_TIMER3:   fire = t3_ovf;
      `MODE_TIMER4:   fire = t4_ovf;
      `MODE_TIMER2:   fire = t2_ovf;
      default:        fire = 1'b0;
    endcase
    next_latch = fire ? word : latch;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_low  <= `DATA_RESET;
      data_high <= `DATA_RESET;
      control   <= `CTL_RESET;
      latch     <= '0;
    end else begin
      data_low  <= next_data_low;
      data_high <= next_data_high;
      control   <= next_control;
      latch     <= next_latch;
    end
  end
endmodule

/* dual_dac_ctrl_props.sv */
// Port checks for the dual converter control
module dual_dac_ctrl_props
  import dac_ctrl_pkg::*;
#(
  parameter int WORD_W = 12
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Register access and timers
  input wire sfr_req_t          sfr,
  input wire logic [7:0]        sfr_rdata,
  input wire logic              timer2_ovf,
  input wire logic              timer3_ovf,
  input wire logic              timer4_ovf,
  // Converter drive
  input wire logic [WORD_W-1:0] chan0_code,
  input wire logic [WORD_W-1:0] chan1_code,
  input wire logic              chan0_enable,
  input wire logic              chan1_enable,
  input wire logic              chan0_pin_oe,
  input wire logic              chan1_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic c0_wr, c1_wr, tmr_any, ev0, ev1;
  assign c0_wr = sfr.write && sfr.addr == 8'hd4 && sfr.page == 8'h00;
  assign c1_wr = sfr.write && sfr.addr == 8'hd4 && sfr.page == 8'h01;
  // Only a high byte write on the channel's own page or a timer pulse may move its code
  assign tmr_any = timer2_ovf || timer3_ovf || timer4_ovf;
  assign ev0 = tmr_any || (sfr.write && sfr.addr == 8'hd3 && sfr.page == 8'h00);
  assign ev1 = tmr_any || (sfr.write && sfr.addr == 8'hd3 && sfr.page == 8'h01);
  oe0_tracks_a: assert property (chan0_pin_oe == chan0_enable) else $error("oe0");
  oe1_tracks_a: assert property (chan1_pin_oe == chan1_enable) else $error("oe1");
  en0_cause_a: assert property ($changed(chan0_enable) |-> $past(c0_wr, 2))
    else $error("en0");
  en1_cause_a: assert property ($changed(chan1_enable) |-> $past(c1_wr, 2))
    else $error("en1");
  code0_cause_a: assert property ($changed(chan0_code) |-> $past(ev0, 2))
    else $error("code0");
  code1_cause_a: assert property ($changed(chan1_code) |-> $past(ev1, 2))
    else $error("code1");
  rdata_idle_a: assert property (!$past(sfr.read) |-> sfr_rdata == 8'h00)
    else $error("idle");
  ctl_unused_a: assert property (
    $past(sfr.read && sfr.addr == 8'hd4) |-> sfr_rdata[6:5] == 2'h0) else $error("unused bits");
  page_other_a: assert property ($past(sfr.read && sfr.page > 8'h01) |-> sfr_rdata == 8'h00)
    else $error("page");
  cover property ($rose(chan0_enable));
  cover property (timer3_ovf ##2 $changed(chan0_code));
  cover property (sfr.read ##1 sfr_rdata != 8'h00);
endmodule
bind dual_dac_update_format_ctrl dual_dac_ctrl_props #(.WORD_W(WORD_W)) props_inst (.*);

/* tb.sv */
// Self-checking bench for the dual converter control
module tb
  import dac_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, en0, en1, oe0, oe1;
  sfr_req_t    sfr;
  logic [2:0]  tmr;
  logic [7:0]  sfr_rdata;
  logic [11:0] code0, code1, e;
  int          errors, samples_checked, cyc;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  dual_dac_update_format_ctrl #(.WORD_W(12)) dual_dac_update_format_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .timer2_ovf(tmr[0]),
    .timer3_ovf(tmr[1]), .timer4_ovf(tmr[2]), .chan0_code(code0), .chan1_code(code1),
    .chan0_enable(en0), .chan1_enable(en1), .chan0_pin_oe(oe0), .chan1_pin_oe(oe1));
  task automatic final_report;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] p, a, d);
    @(posedge clk) sfr <= '{1'b1, 1'b0, p, a, d};
    @(posedge clk) sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] p, a, x);
    @(posedge clk) sfr <= '{1'b0, 1'b1, p, a, 8'h00};
    @(posedge clk) sfr <= '0;
    #1 chk(sfr_rdata === x, "read data");
  endtask
  // Waits out the two-edge lag from request to converter outputs
  task automatic chk_code(input int c, input logic [11:0] x);
    repeat (3) @(posedge clk);
    #1 chk((c == 0 ? code0 : code1) === x, "code");
  endtask
  task automatic chk_en(input int c, input logic x);
    repeat (3) @(posedge clk);
    #1 chk((c == 0 ? {en0, oe0} : {en1, oe1}) === {x, x}, "enable");
  endtask
  task automatic pulse(input int i);
    @(posedge clk) tmr <= 3'(1 << i);
    @(posedge clk) tmr <= 3'h0;
  endtask
  function automatic logic [11:0] word(input logic [7:0] h, l, input logic [2:0] f);
    case (f)
      3'h0: return {h[3:0], l};
      3'h1: return {h[4:0], l[7:1]};
      3'h2: return {h[5:0], l[7:2]};
      3'h3: return {h[6:0], l[7:3]};
      default: return {h, l[7:4]};
    endcase
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    rst_n = 1'b0;
    sfr = '0;
    tmr = 3'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // A write on a foreign page must leave both channels untouched
    wr(8'h02, 8'hd4, 8'hff);
    rd(8'h02, 8'hd4, 8'h00);
    for (int c = 0; c < 2; c++) begin
      for (int a = 2; a < 5; a++) rd(8'(c), 8'(8'hd0 + a), 8'h00);
      rd(8'(c), 8'hd5, 8'h00);
      wr(8'(c), 8'hd4, 8'hff);
      rd(8'(c), 8'hd4, 8'h9f);
      chk_en(c, 1'b1);
      e = 12'h000;
      for (int f = 0; f < 8; f++) begin
        wr(8'(c), 8'hd4, 8'h80 | 8'(f));
        wr(8'(c), 8'hd2, 8'h96);
        chk_code(c, e);
        wr(8'(c), 8'hd3, 8'hc3 + 8'(f));
        e = word(8'hc3 + 8'(f), 8'h96, 3'(f));
        chk_code(c, e);
      end
    end
    e = word(8'hca, 8'h96, 3'h7);
    for (int m = 1; m < 4; m++) begin
      wr(8'h00, 8'hd4, 8'h84 | 8'(m << 3));
      wr(8'h00, 8'hd2, 8'hf0);
      wr(8'h00, 8'hd3, 8'h30 + 8'(m));
      chk_code(0, e);
      pulse((m + 1) % 3);
      pulse((m + 2) % 3);
      chk_code(0, e);
      pulse(m % 3);
      e = {8'h30 + 8'(m), 4'hf};
      chk_code(0, e);
    end
    wr(8'h00, 8'hd4, 8'h00);
    chk_en(0, 1'b0);
    final_report;
  end
endmodule
